// ===== src/device_file_access_unit.sv
// File access engine: open, close, read, write and delete on stored files.
// Assumes a byte-wide storage port with a request/acknowledge handshake.
//
// Notes on behaviour
// - Operation runs only on the execute trigger.
// - Five operations; other codes fail.
// - Open fixes read-only or write-only mode.
// - All file data passes through buffer.
// - Offset positions window inside the file.
// - Length limits bytes mapped into window.
// - Success code after error-free operation.
// - Generic failure code for other errors.
// - Busy code when file is unavailable now.
// - Absent code when file not present.
// - Report bytes actually transferred.
// - Report size of currently chosen file.
// - Chooser covers fourteen named stored files.
// - Stored picture both readable and writable.
// - New program image runs after reboot only.
module device_file_access_unit (
    input  wire logic                       clk_sys_i,                // System clock
    input  wire logic                       sys_rst_i,                // Async reset, high
    input  wire logic [3:0]                 stored_file_chooser_i,    // File code
    input  wire logic [2:0]                 operation_chooser_i,      // Operation code
    input  wire logic                       operation_trigger_i,      // Execute pulse
    input  wire logic                       access_direction_mode_i,  // 0 read, 1 write
    input  wire logic [15:0]                window_byte_offset_i,     // Byte offset
    input  wire logic [15:0]                window_byte_length_i,     // Byte length
    input  wire logic                       reboot_command_i,         // Reboot pulse
    input  wire logic                       buf_host_we_i,            // Buffer write
    input  wire logic [fau_pkg::BUF_AW-1:0] buf_host_addr_i,          // Buffer index
    input  wire logic [7:0]                 buf_host_wdata_i,         // Buffer write byte
    output logic      [7:0]                 buf_host_rdata_o,         // Buffer read byte
    input  wire logic [13:0]                file_present_i,           // Files on this model
    input  wire logic                       stor_busy_i,              // Storage unavailable
    input  wire logic                       stor_ack_i,               // Byte done
    input  wire logic                       stor_err_i,               // Byte failed
    input  wire logic [7:0]                 stor_rdata_i,             // Byte from storage
    output logic                            stor_req_o,               // Byte request
    output logic                            stor_we_o,                // Request is a write
    output logic      [3:0]                 stor_file_o,              // Target file
    output logic      [15:0]                stor_addr_o,              // Byte address
    output logic      [7:0]                 stor_wdata_o,             // Byte to storage
    output logic                            busy_o,                   // Operation running
    output logic                            op_done_o,                // Completion pulse
    output fau_pkg::outcome_t               last_op_outcome_o,        // Outcome code
    output logic      [15:0]                transferred_byte_count_o, // Bytes moved
    output logic      [15:0]                stored_object_bytes_o,    // Chosen file size
    output logic                            image_staged_o,           // Image awaits reboot
    output logic                            image_start_o             // Start new image
);
    fau_pkg::eng_state_t state;
    fau_pkg::op_t        cmd_op;
    logic [3:0]          cmd_file;
    logic                cmd_mode;
    logic [15:0]         cmd_off;
    logic [15:0]         cmd_len;
    logic [15:0]         xfer_n;
    logic [15:0]         xfer_idx;
    fau_pkg::outcome_t   verdict;
    logic                open_valid;
    logic [3:0]          open_file;
    fau_pkg::dir_t       open_mode;
    logic [15:0]         size_tab [14];
    logic                present_sel;
    logic                open_match;
    logic [15:0]         avail;
    logic [15:0]         next_n;
    logic [15:0]         end_pos;
    logic                byte_ok;
    xfer_buf_if          bus ();

    // File state lookups
    assign present_sel = (cmd_file < fau_pkg::NUM_FILES) && file_present_i[cmd_file];
    assign open_match  = open_valid && (open_file == cmd_file);
    assign avail   = (cmd_off < size_tab[cmd_file]) ? (size_tab[cmd_file] - cmd_off) : 16'h0000;
    assign next_n  = (cmd_op == fau_pkg::OP_READ)
                   ? fau_pkg::min16(fau_pkg::min16(cmd_len, fau_pkg::BUF_DEPTH16), avail)
                   : fau_pkg::min16(cmd_len, fau_pkg::BUF_DEPTH16);
    assign end_pos = cmd_off + xfer_idx;
    assign byte_ok = (state == fau_pkg::ST_MOVE) && stor_ack_i && !stor_err_i;

    // Engine sequence
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= fau_pkg::ST_IDLE;
        end else begin
            case (state)
                fau_pkg::ST_IDLE: begin
                    if (operation_trigger_i) begin
                        state <= fau_pkg::ST_CHECK;
                    end
                end
                fau_pkg::ST_CHECK: begin
                    if (present_sel && verdict == fau_pkg::OUT_SUCCESS && next_n != 16'h0000
                        && (cmd_op == fau_pkg::OP_READ || cmd_op == fau_pkg::OP_WRITE)) begin
                        state <= fau_pkg::ST_MOVE;
                    end else begin
                        state <= fau_pkg::ST_DONE;
                    end
                end
                fau_pkg::ST_MOVE: begin
                    if (stor_ack_i && (stor_err_i || xfer_idx + 16'h0001 == xfer_n)) begin
                        state <= fau_pkg::ST_DONE;
                    end
                end
                fau_pkg::ST_DONE: state <= fau_pkg::ST_IDLE;
                default:          state <= fau_pkg::ST_IDLE;
            endcase
        end
    end

    // Command capture on execute; chooser writes alone change only the size output
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_op   <= fau_pkg::OP_OPEN;
            cmd_file <= 4'h0;
            cmd_mode <= 1'b0;
            cmd_off  <= fau_pkg::COUNT_RST;
            cmd_len  <= fau_pkg::COUNT_RST;
        end else if (state == fau_pkg::ST_IDLE && operation_trigger_i) begin
            cmd_op   <= fau_pkg::op_t'(operation_chooser_i);
            cmd_file <= stored_file_chooser_i;
            cmd_mode <= access_direction_mode_i;
            cmd_off  <= window_byte_offset_i;
            cmd_len  <= window_byte_length_i;
        end
    end

    // Verdict for the captured command
    always_comb begin
        verdict = fau_pkg::OUT_SUCCESS;
        if (!present_sel) begin
            verdict = fau_pkg::target_absent_code;
        end else begin
            case (cmd_op)
                fau_pkg::OP_OPEN: begin
                    if (stor_busy_i) verdict = fau_pkg::target_busy_code;
                end
                fau_pkg::OP_CLOSE: begin
                    if (!open_match) verdict = fau_pkg::OUT_FAILURE;
                end
                fau_pkg::OP_READ, fau_pkg::OP_WRITE: begin
                    // Read needs read mode, write needs write mode
                    if (!open_match || (open_mode == fau_pkg::MODE_WRITE)
                                       != (cmd_op == fau_pkg::OP_WRITE)) begin
                        verdict = fau_pkg::OUT_FAILURE;
                    end else if (stor_busy_i) begin
                        verdict = fau_pkg::target_busy_code;
                    end
                end
                fau_pkg::OP_DELETE: begin
                    if (stor_busy_i || open_match) verdict = fau_pkg::target_busy_code;
                end
                default: verdict = fau_pkg::OUT_FAILURE;
            endcase
        end
    end

    // Transfer length and byte index
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xfer_n   <= fau_pkg::COUNT_RST;
            xfer_idx <= fau_pkg::COUNT_RST;
        end else if (state == fau_pkg::ST_CHECK) begin
            xfer_n   <= next_n;
            xfer_idx <= fau_pkg::COUNT_RST;
        end else if (byte_ok) begin
            xfer_idx <= xfer_idx + 16'h0001;
        end
    end

    // Outcome kept for the DONE cycle
    fau_pkg::outcome_t pend_outcome;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend_outcome <= fau_pkg::OUT_SUCCESS;
        end else if (state == fau_pkg::ST_CHECK) begin
            pend_outcome <= verdict;
        end else if (state == fau_pkg::ST_MOVE && stor_ack_i && stor_err_i) begin
            pend_outcome <= fau_pkg::OUT_FAILURE;
        end
    end

    // Visible outcome and count, written once per execute
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_op_outcome_o        <= fau_pkg::OUT_SUCCESS;
            transferred_byte_count_o <= fau_pkg::COUNT_RST;
        end else if (state == fau_pkg::ST_DONE) begin
            last_op_outcome_o        <= pend_outcome;
            transferred_byte_count_o <= xfer_idx;
        end
    end

    // Open file and its access mode
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            open_valid <= 1'b0;
            open_file  <= 4'h0;
            open_mode  <= fau_pkg::MODE_READ;
        end else if (state == fau_pkg::ST_CHECK && verdict == fau_pkg::OUT_SUCCESS) begin
            if (cmd_op == fau_pkg::OP_OPEN) begin
                open_valid <= 1'b1;
                open_file  <= cmd_file;
                open_mode  <= fau_pkg::dir_t'(cmd_mode);
            end else if (cmd_op == fau_pkg::OP_CLOSE) begin
                open_valid <= 1'b0;
            end
        end
    end

    // File size table: writes extend, delete empties
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 14; i++) begin
                size_tab[i] <= fau_pkg::SIZE_RST;
            end
        end else if (state == fau_pkg::ST_CHECK && cmd_op == fau_pkg::OP_DELETE
                     && verdict == fau_pkg::OUT_SUCCESS) begin
            size_tab[cmd_file] <= 16'h0000;
        end else if (state == fau_pkg::ST_DONE && cmd_op == fau_pkg::OP_WRITE
                     && end_pos > size_tab[cmd_file] && present_sel) begin
            size_tab[cmd_file] <= end_pos;
        end
    end

    // Size of the currently chosen file
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stored_object_bytes_o <= fau_pkg::COUNT_RST;
        end else if (stored_file_chooser_i < fau_pkg::NUM_FILES) begin
            stored_object_bytes_o <= size_tab[stored_file_chooser_i];
        end else begin
            stored_object_bytes_o <= 16'h0000;
        end
    end

    // Program image staging; reboot starts it, a same-cycle stage wins
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            image_staged_o <= 1'b0;
            image_start_o  <= 1'b0;
        end else begin
            image_start_o <= reboot_command_i && image_staged_o;
            if (state == fau_pkg::ST_DONE && cmd_op == fau_pkg::OP_WRITE
                && cmd_file == 4'(fau_pkg::program_image_slot)
                && pend_outcome == fau_pkg::OUT_SUCCESS && xfer_idx != 16'h0000) begin
                image_staged_o <= 1'b1;
            end else if (reboot_command_i) begin
                image_staged_o <= 1'b0;
            end
        end
    end

    // Storage request and buffer port
    assign stor_req_o   = (state == fau_pkg::ST_MOVE);
    assign stor_we_o    = (cmd_op == fau_pkg::OP_WRITE);
    assign stor_file_o  = cmd_file;
    assign stor_addr_o  = end_pos;
    assign stor_wdata_o = bus.rdata;
    assign bus.we       = byte_ok && (cmd_op == fau_pkg::OP_READ);
    assign bus.addr     = xfer_idx[fau_pkg::BUF_AW-1:0];
    assign bus.wdata    = stor_rdata_i;
    assign busy_o       = (state != fau_pkg::ST_IDLE);
    assign op_done_o    = (state == fau_pkg::ST_DONE);

    transfer_window_buffer u_buf (
        .clk_sys_i    (clk_sys_i),
        .sys_rst_i    (sys_rst_i),
        .eng          (bus.store),
        .host_we_i    (buf_host_we_i),
        .host_addr_i  (buf_host_addr_i),
        .host_wdata_i (buf_host_wdata_i),
        .host_rdata_o (buf_host_rdata_o)
    );

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_check_absent;
        state == fau_pkg::ST_CHECK && !present_sel;
    endsequence
    sequence s_report(fau_pkg::outcome_t code);
        op_done_o ##1 last_op_outcome_o == code;
    endsequence

    a_idle_no_trig: assert property (state == fau_pkg::ST_IDLE && !operation_trigger_i
        |=> state == fau_pkg::ST_IDLE) else $error("left idle without trigger");
    a_absent_code: assert property (s_check_absent |=> s_report(fau_pkg::target_absent_code))
        else $error("absent file not reported");
    a_busy_code: assert property (state == fau_pkg::ST_CHECK && present_sel
        && cmd_op == fau_pkg::OP_OPEN && stor_busy_i
        |=> s_report(fau_pkg::target_busy_code)) else $error("busy not reported");
    a_bad_op_code: assert property (state == fau_pkg::ST_CHECK && present_sel
        && cmd_op > fau_pkg::OP_DELETE |=> s_report(fau_pkg::OUT_FAILURE))
        else $error("bad op not failed");
    a_dir_refuse: assert property (state == fau_pkg::ST_CHECK && present_sel && open_match
        && cmd_op == fau_pkg::OP_READ && open_mode == fau_pkg::MODE_WRITE
        |=> s_report(fau_pkg::OUT_FAILURE)) else $error("wrong direction allowed");
    a_outcome_hold: assert property ($changed(last_op_outcome_o)
        || $changed(transferred_byte_count_o) |-> $past(op_done_o))
        else $error("status changed outside completion");
    a_count_limit: assert property (op_done_o |=> transferred_byte_count_o <= $past(cmd_len)
        && transferred_byte_count_o <= fau_pkg::BUF_DEPTH16)
        else $error("count exceeds window");
    a_req_addr: assert property (stor_req_o |-> stor_addr_o == cmd_off + xfer_idx
        && xfer_idx < xfer_n) else $error("request outside window");
    a_image_start: assert property (image_start_o |-> $past(reboot_command_i)
        && $past(image_staged_o)) else $error("image started without reboot");
endmodule : device_file_access_unit

// ===== include/fau_pkg.sv
// Constants, types and helpers for the device file access unit.
// Assumes one system clock; every file is addressed by a 4-bit chooser code.
package fau_pkg;

    // Transfer window buffer geometry
    localparam int          BUF_DEPTH  = 16;
    localparam int          BUF_AW     = 4;
    localparam logic [15:0] BUF_DEPTH16 = 16'h0010;

    // Number of addressable stored files
    localparam logic [3:0]  NUM_FILES  = 4'hE;

    // Values after reset
    localparam logic [15:0] SIZE_RST   = 16'h0040;
    localparam logic [15:0] COUNT_RST  = 16'h0000;
    localparam logic [7:0]  BYTE_RST   = 8'h00;

    // Stored file chooser codes
    typedef enum logic [3:0] {
        program_image_slot    = 4'h0,
        settings_slot_a       = 4'h1,
        settings_slot_b       = 4'h2,
        settings_slot_c       = 4'h3,
        settings_slot_d       = 4'h4,
        brightness_table_slot = 4'h5,
        factory_shading_slot  = 4'h6,
        shading_slot_a        = 4'h7,
        shading_slot_b        = 4'h8,
        shading_slot_c        = 4'h9,
        shading_slot_d        = 4'hA,
        hue_matrix_slot       = 4'hB,
        stored_picture_slot   = 4'hC,
        licence_text_slot     = 4'hD
    } file_id_t;

    // Operation chooser codes
    typedef enum logic [2:0] {
        OP_OPEN   = 3'h0,
        OP_CLOSE  = 3'h1,
        OP_READ   = 3'h2,
        OP_WRITE  = 3'h3,
        OP_DELETE = 3'h4
    } op_t;

    // Access direction mode
    typedef enum logic {
        MODE_READ  = 1'b0,
        MODE_WRITE = 1'b1
    } dir_t;

    // Last operation outcome codes
    typedef enum logic [1:0] {
        OUT_SUCCESS        = 2'h0,
        OUT_FAILURE        = 2'h1,
        target_busy_code   = 2'h2,
        target_absent_code = 2'h3
    } outcome_t;

    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_CHECK = 2'h1,
        ST_MOVE  = 2'h2,
        ST_DONE  = 2'h3
    } eng_state_t;

    // Smaller of two byte counts
    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction : min16

endpackage : fau_pkg

// ===== include/xfer_buf_if.sv
// Engine-side port of the transfer window buffer.
// Assumes the buffer answers reads combinationally from its flip-flops.
interface xfer_buf_if;
    logic                         we;     // Engine writes a byte
    logic [fau_pkg::BUF_AW-1:0]   addr;   // Byte index in window
    logic [7:0]                   wdata;  // Byte from storage
    logic [7:0]                   rdata;  // Byte toward storage

    modport engine (output we, output addr, output wdata, input rdata);
    modport store  (input we, input addr, input wdata, output rdata);
endinterface : xfer_buf_if

// ===== src/transfer_window_buffer.sv
// Byte buffer between the host application and the file storage engine.
// Assumes the host leaves the buffer alone while the engine is busy.
module transfer_window_buffer (
    input  wire logic                       clk_sys_i,       // System clock
    input  wire logic                       sys_rst_i,       // Async reset, high
    xfer_buf_if.store                       eng,             // Engine port
    input  wire logic                       host_we_i,       // Host byte write
    input  wire logic [fau_pkg::BUF_AW-1:0] host_addr_i,     // Host byte index
    input  wire logic [7:0]                 host_wdata_i,    // Host write byte
    output logic      [7:0]                 host_rdata_o     // Host read byte
);
    logic [7:0] mem [fau_pkg::BUF_DEPTH];

    // Storage; engine wins a clash on the same cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < fau_pkg::BUF_DEPTH; i++) begin
                mem[i] <= fau_pkg::BYTE_RST;
            end
        end else if (eng.we) begin
            mem[eng.addr] <= eng.wdata;
        end else if (host_we_i) begin
            mem[host_addr_i] <= host_wdata_i;
        end
    end

    // Registered host read
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            host_rdata_o <= fau_pkg::BYTE_RST;
        end else begin
            host_rdata_o <= mem[host_addr_i];
        end
    end

    // Engine read straight from the flops
    assign eng.rdata = mem[eng.addr];
endmodule : transfer_window_buffer

// ===== sim/file_store_model.sv
// Behavioural byte storage behind the engine's request/acknowledge port.
// Assumes the request and address hold steady until the acknowledge edge.
module file_store_model (
    input  wire logic        clk_sys_i, // System clock
    input  wire logic        req_i,     // Byte request
    input  wire logic [15:0] addr_i,    // Byte address
    input  wire logic [3:0]  lag_i,     // Extra wait cycles
    input  wire logic        fail_i,    // Answer with error
    output logic             ack_o,     // Byte done
    output logic             err_o,     // Byte failed
    output logic      [7:0]  rdata_o    // Read byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt = 4'h0;
    initial begin
        ack_o = 1'b0;
        err_o = 1'b0;
        rdata_o = 8'h00;
    end
    // One-cycle answer after lag; data line scrambled once released
    always @(posedge clk_sys_i) begin
        if (ack_o) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            rdata_o <= ~rdata_o;
            wait_cnt <= 4'h0;
        end else if (req_i) begin
            if (wait_cnt == lag_i) begin
                ack_o <= 1'b1;
                err_o <= fail_i;
                rdata_o <= addr_i[7:0] + 8'h5A;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : file_store_model

// ===== sim/device_file_access_unit_test.sv
// Self-checking bench for the file access engine and its byte storage.
// Assumes the storage model answers every request; inputs move 1 ns after edges.
module device_file_access_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [3:0] f; logic [2:0] o; logic [1:0] e;} row_t;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, trig = 1'b0, mode = 1'b0, reboot = 1'b0;
    logic hwe = 1'b0, sbusy = 1'b0, fail = 1'b0, ack, err, req, we, busy, done, staged, start;
    logic [3:0] file = 4'hC, haddr = 4'h0, lag = 4'h0, sfile;
    logic [2:0] op = 3'h0;
    logic [7:0] hwdata = 8'h00, hrdata, srdata, swdata;
    logic [15:0] off = 16'h0000, len = 16'h0000, saddr, count, size;
    fau_pkg::outcome_t outcome;
    int err_total = 0, check_count = 0;
    // Codes: ops 0 open 1 close 3 write 4 delete 5 unused; file 13 absent here
    row_t rows [9] = '{'{4'hE, 3'h0, 2'h3}, '{4'hD, 3'h0, 2'h3}, '{4'h1, 3'h1, 2'h1},
        '{4'h1, 3'h5, 2'h1}, '{4'h1, 3'h0, 2'h0}, '{4'h1, 3'h3, 2'h1},
        '{4'h1, 3'h4, 2'h2}, '{4'h1, 3'h1, 2'h0}, '{4'h2, 3'h4, 2'h0}};
    always #25 clk_sys_i = ~clk_sys_i;
    device_file_access_unit u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .stored_file_chooser_i(file), .operation_chooser_i(op), .operation_trigger_i(trig),
        .access_direction_mode_i(mode), .window_byte_offset_i(off),
        .window_byte_length_i(len), .reboot_command_i(reboot), .buf_host_we_i(hwe),
        .buf_host_addr_i(haddr), .buf_host_wdata_i(hwdata), .buf_host_rdata_o(hrdata),
        .file_present_i(14'h1FFF), .stor_busy_i(sbusy), .stor_ack_i(ack), .stor_err_i(err),
        .stor_rdata_i(srdata), .stor_req_o(req), .stor_we_o(we), .stor_file_o(sfile),
        .stor_addr_o(saddr), .stor_wdata_o(swdata), .busy_o(busy), .op_done_o(done),
        .last_op_outcome_o(outcome), .transferred_byte_count_o(count),
        .stored_object_bytes_o(size), .image_staged_o(staged), .image_start_o(start));
    file_store_model u_store (.clk_sys_i(clk_sys_i), .req_i(req), .addr_i(saddr),
        .lag_i(lag), .fail_i(fail), .ack_o(ack), .err_o(err), .rdata_o(srdata));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Every byte handed to storage: direction, target file, and buffer byte i at offset+i
    always @(posedge clk_sys_i) begin
        if (req === 1'b1 && ack === 1'b1) begin
            check({7'h0, we, 4'h0, sfile}, {7'h0, op == 3'h3, 4'h0, file});
            if (we === 1'b1) begin
                check({8'h0, swdata}, {8'h0, 8'hA0 + saddr[7:0] - off[7:0]});
            end
        end
    end
    // One execute pulse, then wait for completion and one more edge
    task automatic exec(input logic [3:0] f, input logic [2:0] o, input logic m,
                        input logic [15:0] ofs, input logic [15:0] n);
        int k;
        logic [1:0] prev;
        prev = outcome;
        file = f; op = o; mode = m; off = ofs; len = n; trig = 1'b1;
        @(posedge clk_sys_i);
        #1 trig = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 200) begin
            @(posedge clk_sys_i);
            #1 k++;
        end
        check({14'h0, outcome}, {14'h0, prev});
        if (k == 200) err_total++;
        @(posedge clk_sys_i);
        #1;
    endtask : exec
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #200us;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        @(posedge clk_sys_i);
        #1 check({busy, req, 12'h0, outcome}, 16'h0000);
        check(size, 16'h0040);
        // Status outcomes of two opens, close, an unused code, open, a refused write, delete, close and delete, in order
        foreach (rows[i]) begin
            exec(rows[i].f, rows[i].o, 1'b0, 16'h0000, 16'h0000);
            check({14'h0, outcome}, {14'h0, rows[i].e});
        end
        check(size, 16'h0000);
        sbusy = 1'b1;
        exec(4'h3, 3'h0, 1'b0, 16'h0000, 16'h0000);
        check({14'h0, outcome}, 16'h0002);
        sbusy = 1'b0;
        // Read at the end of the file: window clipped to two bytes
        exec(4'hC, 3'h0, 1'b0, 16'h0000, 16'h0000);
        op = 3'h2;
        repeat (3) @(posedge clk_sys_i);
        #1 check({busy, req}, 16'h0000);
        lag = 4'h3;
        exec(4'hC, 3'h2, 1'b0, 16'h003E, 16'h0008);
        check({outcome, count[13:0]}, 16'h0002);
        for (int i = 0; i < 2; i++) begin
            haddr = i[3:0];
            @(posedge clk_sys_i);
            #1 check({8'h0, hrdata}, 16'h0098 + i[15:0]);
        end
        fail = 1'b1;
        exec(4'hC, 3'h2, 1'b0, 16'h0000, 16'h0002);
        check({outcome, count[13:0]}, 16'h4000);
        fail = 1'b0;
        lag = 4'h0;
        // Upload past the end of program image and picture
        for (int j = 0; j < 2; j++) begin
            exec(j ? 4'hC : 4'h0, 3'h0, 1'b1, 16'h0000, 16'h0000);
            for (int i = 0; i < 3; i++) begin
                haddr = i[3:0];
                hwdata = 8'hA0 + i[7:0];
                hwe = 1'b1;
                @(posedge clk_sys_i);
                #1;
            end
            hwe = 1'b0;
            exec(j ? 4'hC : 4'h0, 3'h3, 1'b1, 16'h0040, 16'h0003);
            check({outcome, count[13:0]}, 16'h0003);
            // Size output lags the size table by one cycle
            @(posedge clk_sys_i);
            #1 check(size, 16'h0043);
        end
        // Read on a write-only file, then a write while storage is busy
        exec(4'hC, 3'h2, 1'b0, 16'h0000, 16'h0002);
        check({outcome, count[13:0]}, 16'h4000);
        sbusy = 1'b1;
        exec(4'hC, 3'h3, 1'b1, 16'h0000, 16'h0002);
        check({outcome, count[13:0]}, 16'h8000);
        sbusy = 1'b0;
        check({15'h0, staged}, 16'h0001);
        reboot = 1'b1;
        @(posedge clk_sys_i);
        #1 reboot = 1'b0;
        check({staged, start}, 16'h0001);
        complete_run();
    end
endmodule : device_file_access_unit_test
